// File: common/pmcs_consts.svh
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define PMCS_ADDR_CONTROL    5'h00
`define PMCS_ADDR_STATUS     5'h01
`define PMCS_ADDR_EXT_STATUS 5'h0f

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define PMCS_CTL_RESET      15
`define PMCS_CTL_LOOPBACK   14
`define PMCS_CTL_SPEED_LSB  13
`define PMCS_CTL_AN_EN      12
`define PMCS_CTL_PWR_DOWN   11
`define PMCS_CTL_ISOLATE    10
`define PMCS_CTL_AN_RESTART 9
`define PMCS_CTL_DUPLEX     8
`define PMCS_CTL_SPEED_MSB  6

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define PMCS_STS_ABIL_HI     15
`define PMCS_STS_ABIL_LO     9
`define PMCS_STS_EXT_PRESENT 8
`define PMCS_STS_AN_DONE     5
`define PMCS_STS_AN_ABLE     3
`define PMCS_STS_LINK        2
`define PMCS_STS_EXT_CAP     0
`define PMCS_EXT_ABIL_HI     15
`define PMCS_EXT_ABIL_LO     12

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMCS_ABIL_BASIC_RST  7'h3c
`define PMCS_ABIL_EXT_RST    4'h3
`define PMCS_AN_EN_RST       1'h1

// ----------------------------------------------------------------
// management frame bit counts
// ----------------------------------------------------------------
`define PMCS_MDIO_PRE_BITS   6'h20
`define PMCS_MDIO_HDR_LAST   6'h0d
`define PMCS_MDIO_DATA_LAST  6'h0f

`endif

// File: common/pmcs_pkg.sv
package pmcs_pkg;
`include "pmcs_consts.svh"

    typedef enum logic [1:0] {
        PMCS_SPD_10   = 2'h0,
        PMCS_SPD_100  = 2'h1,
        PMCS_SPD_1000 = 2'h2,
        PMCS_SPD_RSVD = 2'h3
    } pmcs_speed_t;

    typedef enum logic [1:0] {
        PMCS_GIG_ADVERT = 2'h0,
        PMCS_GIG_SILENT = 2'h1,
        PMCS_GIG_SIGNAL = 2'h2
    } pmcs_gig_mode_t;

    typedef enum logic [3:0] {
        PMCS_MD_PRE  = 4'b0001,
        PMCS_MD_HDR  = 4'b0010,
        PMCS_MD_TA   = 4'b0100,
        PMCS_MD_DATA = 4'b1000
    } pmcs_mdio_st_t;

    typedef struct packed {
        pmcs_mdio_st_t st;
        logic          mdc;
        logic [5:0]    cnt;
        logic [15:0]   sh;
        logic          is_read;
        logic [4:0]    addr;
        logic          wr;
        logic          mdio_o;
        logic          mdio_oe;
    } pmcs_mdio_state_t;

    typedef struct packed {
        logic good;
        logic link;
        logic an_done;
    } pmcs_link_state_t;

    typedef struct packed {
        logic        an_en;
        logic        loopback;
        logic        pwr_down;
        logic        isolate;
        logic        duplex;
        pmcs_speed_t speed;
        logic        restart_p;
        logic        reset_p;
        pmcs_speed_t line_speed;
        logic        line_fd;
        logic        tx_silent;
        logic        gig_adv;
    } pmcs_ctl_state_t;

endpackage

// File: common/pmcs_reg_if.sv
`timescale 1ns/1ps

interface pmcs_reg_if;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic [15:0] rdata;

    modport master (output wr, output addr, output wdata, input rdata);
    modport slave  (input wr, input addr, input wdata, output rdata);
endinterface

// File: hw/pmcs_mdio_slave.sv
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module pmcs_mdio_slave
    import pmcs_pkg::*;
(
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    input  wire logic       i_clk_en,
    // management pins
    input  wire logic       i_mdc,
    input  wire logic       i_mdio,
    output logic            o_mdio,
    output logic            o_mdio_oe,
    input  wire logic [4:0] i_phy_addr,
    // register side
    pmcs_reg_if.master      bus
);
    pmcs_mdio_state_t s_q;
    pmcs_mdio_state_t s_d;
    logic [15:0]      sh_in;

    assign sh_in = {s_q.sh[14:0], i_mdio};

    always_comb begin
        s_d     = s_q;
        s_d.mdc = i_mdc;
        s_d.wr  = 1'b0;
        if (i_mdc && !s_q.mdc) begin
            unique case (s_q.st)
                PMCS_MD_PRE: begin
                    if (i_mdio) begin
                        if (s_q.cnt != `PMCS_MDIO_PRE_BITS)
                            s_d.cnt = s_q.cnt + 6'h01;
                    end else if (s_q.cnt == `PMCS_MDIO_PRE_BITS) begin
                        s_d.st  = PMCS_MD_HDR;
                        s_d.cnt = 6'h01;
                        s_d.sh  = 16'h0000;
                    end else begin
                        s_d.cnt = 6'h00;
                    end
                end
                PMCS_MD_HDR: begin
                    s_d.sh  = sh_in;
                    s_d.cnt = s_q.cnt + 6'h01;
                    if (s_q.cnt == `PMCS_MDIO_HDR_LAST) begin
                        // start 01, op 10 read / 01 write, our address
                        s_d.cnt = 6'h00;
                        s_d.st  = PMCS_MD_PRE;
                        if (sh_in[13:12] == 2'h1 && sh_in[9:5] == i_phy_addr
                            && (sh_in[11:10] == 2'h1
                                || sh_in[11:10] == 2'h2)) begin
                            s_d.st      = PMCS_MD_TA;
                            s_d.is_read = sh_in[11];
                            s_d.addr    = sh_in[4:0];
                        end
                    end
                end
                PMCS_MD_TA: begin
                    s_d.cnt = s_q.cnt + 6'h01;
                    if (s_q.is_read) begin
                        s_d.mdio_oe = 1'b1;
                        s_d.mdio_o  = 1'b0;
                    end
                    if (s_q.cnt == 6'h01) begin
                        s_d.st  = PMCS_MD_DATA;
                        s_d.cnt = 6'h00;
                        // snapshot so the word cannot tear mid-frame
                        s_d.sh  = bus.rdata;
                        if (s_q.is_read)
                            s_d.mdio_o = bus.rdata[15];
                    end
                end
                PMCS_MD_DATA: begin
                    s_d.cnt    = s_q.cnt + 6'h01;
                    s_d.sh     = sh_in;
                    s_d.mdio_o = s_q.sh[14];
                    if (s_q.cnt == `PMCS_MDIO_DATA_LAST) begin
                        s_d.wr      = !s_q.is_read;
                        s_d.st      = PMCS_MD_PRE;
                        s_d.cnt     = 6'h00;
                        s_d.mdio_oe = 1'b0;
                        s_d.mdio_o  = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            s_q         <= '0;
            s_q.st      <= PMCS_MD_PRE;
        end else if (i_clk_en) begin
            s_q <= s_d;
        end
    end

    assign bus.wr    = s_q.wr && i_clk_en;
    assign bus.addr  = s_q.addr;
    assign bus.wdata = s_q.sh;
    assign o_mdio    = s_q.mdio_o;
    assign o_mdio_oe = s_q.mdio_oe;
endmodule

// File: hw/pmcs_link_mon.sv
`timescale 1ns/1ps

module pmcs_link_mon
    import pmcs_pkg::*;
(
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_reset,
    input  wire logic i_clk_en,
    // arbitration side
    input  wire logic i_flp_link_good,
    input  wire logic i_link_lost,
    input  wire logic i_an_en,
    // status
    output logic      o_link,
    output logic      o_an_done
);
    pmcs_link_state_t s_q;
    pmcs_link_state_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.good = i_flp_link_good;
        // only entry into link good raises the bit
        if (i_flp_link_good && !s_q.good) begin
            s_d.link    = 1'b1;
            s_d.an_done = i_an_en;
        end
        // loss wins over a same-cycle entry
        if (i_link_lost) begin
            s_d.link    = 1'b0;
            s_d.an_done = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset)
            s_q <= '0;
        else if (i_clk_en)
            s_q <= s_d;
    end

    assign o_link    = s_q.link;
    assign o_an_done = s_q.an_done;
endmodule

// File: hw/pmcs_phy_regs.sv
`timescale 1ns/1ps
`include "pmcs_consts.svh"

module pmcs_phy_regs
    import pmcs_pkg::*;
#(
    parameter logic [6:0]     P_ABIL_BASIC   = `PMCS_ABIL_BASIC_RST,
    parameter logic [3:0]     P_ABIL_EXT     = `PMCS_ABIL_EXT_RST,
    parameter pmcs_gig_mode_t P_GIG_MODE     = PMCS_GIG_SIGNAL,
    parameter logic           P_SHOW_SPEED   = 1'b1
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    // management pins
    input  wire logic        i_mdc,
    input  wire logic        i_mdio,
    output logic             o_mdio,
    output logic             o_mdio_oe,
    input  wire logic [4:0]  i_phy_addr,
    // arbitration state
    input  wire logic        i_flp_link_good,
    input  wire logic        i_link_lost,
    input  wire pmcs_speed_t i_link_speed,
    // line configuration
    output logic             o_an_enable,
    output logic             o_an_restart,
    output logic             o_soft_reset,
    output logic             o_loopback,
    output logic             o_power_down,
    output logic             o_isolate,
    output pmcs_speed_t      o_line_speed,
    output logic             o_line_full_duplex,
    output logic             o_tx_silent,
    output logic             o_gig_advert_only
);
    // ----------------------------------------------------------------
    // abilities
    // ----------------------------------------------------------------
    // basic ability bits: T4, 100 X pair, 10 pair, T2 pair
    localparam logic AB_T4    = P_ABIL_BASIC[6];
    localparam logic AB_X_FD  = P_ABIL_BASIC[5];
    localparam logic AB_X_HD  = P_ABIL_BASIC[4];
    localparam logic AB_10_FD = P_ABIL_BASIC[3];
    localparam logic AB_10_HD = P_ABIL_BASIC[2];
    localparam logic AB_T2_FD = P_ABIL_BASIC[1];
    localparam logic AB_T2_HD = P_ABIL_BASIC[0];

    // extended bits only count with gigabit twisted pair present
    localparam logic EXT_PRESENT = |P_ABIL_EXT[1:0];
    localparam logic [3:0] EXT_SHOWN =
        EXT_PRESENT ? P_ABIL_EXT : 4'h0;
    localparam logic GX_FD = EXT_SHOWN[3];
    localparam logic GX_HD = EXT_SHOWN[2];
    localparam logic GT_FD = EXT_SHOWN[1];
    localparam logic GT_HD = EXT_SHOWN[0];

    localparam logic SUP_10 =
        AB_10_FD
        | AB_10_HD;
    localparam logic SUP_100 =
        AB_T4
        | AB_X_FD
        | AB_X_HD
        | AB_T2_FD
        | AB_T2_HD;

    localparam logic SUP_1000 = |EXT_SHOWN;

    localparam logic SUP_FD =
        AB_X_FD
        | AB_10_FD
        | AB_T2_FD
        | GX_FD
        | GT_FD;
    localparam logic SUP_HD =
        AB_T4
        | AB_X_HD
        | AB_10_HD
        | AB_T2_HD
        | GX_HD
        | GT_HD;

    localparam logic ONE_DUPLEX = SUP_FD ^ SUP_HD;

    // a device with both duplexes starts half
    localparam logic DUPLEX_RST = ONE_DUPLEX & SUP_FD;

    // highest reported speed wins at reset
    localparam pmcs_speed_t SPEED_RST =
        SUP_1000 ? PMCS_SPD_1000 :
        SUP_100  ? PMCS_SPD_100  : PMCS_SPD_10;

    // ----------------------------------------------------------------
    // submodules
    // ----------------------------------------------------------------
    pmcs_reg_if bus ();

    logic            link_up;
    logic            an_done;
    pmcs_ctl_state_t s_q;
    pmcs_ctl_state_t s_d;

    // serial frames in, register strobes out
    pmcs_mdio_slave u_mdio (
        .i_clock    (i_clock),
        .i_reset    (i_reset),
        .i_clk_en   (i_clk_en),
        .i_mdc      (i_mdc),
        .i_mdio     (i_mdio),
        .o_mdio     (o_mdio),
        .o_mdio_oe  (o_mdio_oe),
        .i_phy_addr (i_phy_addr),
        .bus        (bus.master)
    );

    // link status and completion flags
    pmcs_link_mon u_link (
        .i_clock         (i_clock),
        .i_reset         (i_reset),
        .i_clk_en        (i_clk_en),
        .i_flp_link_good (i_flp_link_good),
        .i_link_lost     (i_link_lost),
        .i_an_en         (s_q.an_en),
        .o_link          (link_up),
        .o_an_done       (an_done)
    );

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // the reserved code is never a supported speed
    function automatic logic speed_ok(input pmcs_speed_t sp);
        unique case (sp)
            PMCS_SPD_10:   speed_ok = SUP_10;
            PMCS_SPD_100:  speed_ok = SUP_100;
            PMCS_SPD_1000: speed_ok = SUP_1000;
            default:       speed_ok = 1'b0;
        endcase
    endfunction

    // one set of defaults for i_reset and the soft reset bit
    function automatic pmcs_ctl_state_t ctl_reset();
        pmcs_ctl_state_t r;
        r            = '0;
        r.an_en      = `PMCS_AN_EN_RST;
        r.duplex     = DUPLEX_RST;
        r.speed      = SPEED_RST;
        r.line_speed = SPEED_RST;
        r.line_fd    = DUPLEX_RST;
        return r;
    endfunction

    // ----------------------------------------------------------------
    // write decode and forced configuration
    // ----------------------------------------------------------------
    pmcs_speed_t wr_speed;
    logic        wr_ctl;

    assign wr_speed = pmcs_speed_t'({bus.wdata[`PMCS_CTL_SPEED_MSB],
                                     bus.wdata[`PMCS_CTL_SPEED_LSB]});
    // status and extended status have no write path at all
    assign wr_ctl = bus.wr
                 && bus.addr == `PMCS_ADDR_CONTROL;

    always_comb begin
        s_d           = s_q;
        s_d.restart_p = 1'b0;
        s_d.reset_p   = 1'b0;
        if (wr_ctl) begin
            s_d.loopback  = bus.wdata[`PMCS_CTL_LOOPBACK];
            s_d.an_en     = bus.wdata[`PMCS_CTL_AN_EN];
            s_d.pwr_down  = bus.wdata[`PMCS_CTL_PWR_DOWN];
            s_d.isolate   = bus.wdata[`PMCS_CTL_ISOLATE];
            s_d.restart_p = bus.wdata[`PMCS_CTL_AN_RESTART];
            if (!ONE_DUPLEX) begin
                s_d.duplex = bus.wdata[`PMCS_CTL_DUPLEX];
            end
            if (speed_ok(wr_speed)) begin
                s_d.speed = wr_speed;
            end

            if (bus.wdata[`PMCS_CTL_RESET]) begin
                // self-clearing: defaults back, one pulse out
                s_d         = ctl_reset();
                s_d.reset_p = 1'b1;
            end
        end

        // forced settings reach the line only with negotiation off
        s_d.tx_silent = 1'b0;
        s_d.gig_adv   = 1'b0;

        if (!s_d.an_en) begin
            s_d.line_fd    = s_d.duplex;
            s_d.line_speed = s_d.speed;
            unique case (s_d.speed)
                // gigabit behaviour is fixed when the block is built
                PMCS_SPD_1000: begin
                    s_d.tx_silent = (P_GIG_MODE == PMCS_GIG_SILENT);
                    s_d.gig_adv   = (P_GIG_MODE == PMCS_GIG_ADVERT);
                end
                PMCS_SPD_RSVD: begin
                    s_d.tx_silent = 1'b1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            s_q <= ctl_reset();
        end else if (i_clk_en) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    pmcs_speed_t rd_speed;
    logic [15:0] ctl_word;
    logic [15:0] sts_word;

    // negotiated speed shown only while it is meaningful
    always_comb begin
        rd_speed = s_q.speed;
        if (P_SHOW_SPEED && s_q.an_en && link_up)
            rd_speed = i_link_speed;
    end

    // pulse bits 15 and 9 always read back as zero
    always_comb begin
        ctl_word                       = 16'h0000;
        ctl_word[`PMCS_CTL_LOOPBACK]   = s_q.loopback;
        ctl_word[`PMCS_CTL_SPEED_LSB]  = rd_speed[0];
        ctl_word[`PMCS_CTL_AN_EN]      = s_q.an_en;
        ctl_word[`PMCS_CTL_PWR_DOWN]   = s_q.pwr_down;
        ctl_word[`PMCS_CTL_ISOLATE]    = s_q.isolate;
        ctl_word[`PMCS_CTL_DUPLEX]     = s_q.duplex;
        ctl_word[`PMCS_CTL_SPEED_MSB]  = rd_speed[1];
    end

    // bit 0 says the extended register set exists
    always_comb begin
        sts_word = 16'h0000;
        sts_word[`PMCS_STS_ABIL_HI:`PMCS_STS_ABIL_LO] = P_ABIL_BASIC;
        sts_word[`PMCS_STS_EXT_PRESENT] = EXT_PRESENT;
        sts_word[`PMCS_STS_AN_DONE]     = an_done;
        sts_word[`PMCS_STS_AN_ABLE]     = 1'b1;
        sts_word[`PMCS_STS_LINK]        = link_up;
        sts_word[`PMCS_STS_EXT_CAP]     = 1'b1;
    end

    always_comb begin
        unique case (bus.addr)
            `PMCS_ADDR_CONTROL:    bus.rdata = ctl_word;
            `PMCS_ADDR_STATUS:     bus.rdata = sts_word;
            `PMCS_ADDR_EXT_STATUS:
                bus.rdata = {EXT_SHOWN, 12'h000};
            default:               bus.rdata = 16'h0000;
        endcase
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // control levels and one-cycle pulses
    assign o_an_enable        = s_q.an_en;
    assign o_an_restart       = s_q.restart_p;
    assign o_soft_reset       = s_q.reset_p;
    assign o_loopback         = s_q.loopback;
    assign o_power_down       = s_q.pwr_down;
    assign o_isolate          = s_q.isolate;

    // applied line setup, frozen while negotiating
    assign o_line_speed       = s_q.line_speed;
    assign o_line_full_duplex = s_q.line_fd;
    assign o_tx_silent        = s_q.tx_silent;
    assign o_gig_advert_only  = s_q.gig_adv;
endmodule

// File: verif/pmcs_link_partner.sv
`timescale 1ns/1ps

module pmcs_link_partner
    import pmcs_pkg::*;
(
    // clock
    input  wire logic   i_clock,
    // arbitration view of the cable partner
    output logic        o_link_good,
    output logic        o_link_lost,
    output pmcs_speed_t o_link_speed
);
    initial begin
        o_link_good = 1'b0;
        o_link_lost = 1'b0;
        o_link_speed = PMCS_SPD_10;
    end

    // slow partners take a while to reach link good
    task automatic link_up(input pmcs_speed_t spd, input int slow);
        o_link_speed = spd;
        repeat (slow) @(negedge i_clock);
        o_link_good = 1'b1;
        repeat (3) @(negedge i_clock);
    endtask

    // speed is meaningless once down, so it is scrambled
    task automatic link_down();
        o_link_good = 1'b0;
        o_link_lost = 1'b1;
        o_link_speed = pmcs_speed_t'(~o_link_speed);
        @(negedge i_clock);
        o_link_lost = 1'b0;
        repeat (2) @(negedge i_clock);
    endtask
endmodule

// File: verif/pmcs_phy_regs_properties.sv
`timescale 1ns/1ps

module pmcs_phy_regs_props
    import pmcs_pkg::*;
(
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_reset,
    // management pins
    input wire logic        i_mdc,
    input wire logic        o_mdio,
    input wire logic        o_mdio_oe,
    // line configuration
    input wire logic        o_an_enable,
    input wire logic        o_an_restart,
    input wire logic        o_soft_reset,
    input wire pmcs_speed_t o_line_speed,
    input wire logic        o_line_full_duplex,
    input wire logic        o_tx_silent,
    input wire logic        o_gig_advert_only
);
    default clocking dcb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    // ----------
    // checks
    // ----------
    chk_reset_values: assert property (
        $fell(i_reset) |-> o_an_enable && !o_line_full_duplex
            && o_line_speed == PMCS_SPD_1000)
        else $error("control not at reset values");
    chk_reserved_silent: assert property (
        o_tx_silent == (o_line_speed == PMCS_SPD_RSVD))
        else $error("silence does not follow reserved speed");
    chk_gig_signal: assert property (
        o_line_speed == PMCS_SPD_1000 |-> !o_gig_advert_only && !o_tx_silent)
        else $error("forced gigabit does not signal");
    chk_speed_legal: assert property (
        o_line_speed != PMCS_SPD_RSVD)
        else $error("unsupported speed applied");
    chk_an_freeze: assert property (
        o_an_enable && $past(o_an_enable) && !o_soft_reset
            |-> $stable(o_line_speed) && $stable(o_line_full_duplex))
        else $error("line changed while negotiating");
    chk_mdio_on_rise: assert property (
        !$stable(o_mdio) |-> $past(i_mdc) && !$past(i_mdc, 2))
        else $error("data out moved away from a clock rise");
    chk_ta_zero: assert property (
        $rose(o_mdio_oe) |-> !o_mdio)
        else $error("turnaround not driven low");
    chk_oe_hold: assert property (
        $rose(o_mdio_oe) |-> o_mdio_oe [*8])
        else $error("read drive too short");
    chk_oe_quiet: assert property (
        $fell(i_reset) |-> !o_mdio_oe [*8])
        else $error("drive right after reset");
    chk_restart_pulse: assert property (
        o_an_restart |=> !o_an_restart)
        else $error("restart longer than one cycle");
    chk_soft_reset: assert property (
        o_soft_reset |=> !o_soft_reset && o_an_enable
            && o_line_speed == PMCS_SPD_1000)
        else $error("soft reset did not restore control");

    cover property ($rose(o_mdio_oe));
    cover property (o_soft_reset);
    cover property ($fell(o_an_enable));
endmodule

bind pmcs_phy_regs pmcs_phy_regs_props pmcs_phy_regs_props_i (
    .i_clock, .i_reset, .i_mdc, .o_mdio, .o_mdio_oe, .o_an_enable,
    .o_an_restart, .o_soft_reset, .o_line_speed, .o_line_full_duplex,
    .o_tx_silent, .o_gig_advert_only
);

// File: verif/testbench.sv
`timescale 1ns/1ps

module testbench
    import pmcs_pkg::*;
;
    logic        i_clock = 1'b0;
    logic        i_reset = 1'b1;
    logic        mdc = 1'b0;
    logic        drv = 1'b1;
    logic        drv_en = 1'b0;
    logic [4:0]  phy_addr = 5'h05;
    logic        o_mdio, o_mdio_oe, good, lost;
    pmcs_speed_t link_spd, o_line_speed, spd;
    logic        o_line_full_duplex, o_tx_silent, o_gig_advert_only;
    logic        o_an_enable, o_loopback, o_power_down, o_isolate;
    logic [31:0] shreg;
    logic [15:0] exp_q[$];
    int          err_total = 0;
    int          checks = 0;
    int          seed = 45;
    int          cyc = 0;
    // pull-up on the shared data line
    wire mdio_line = o_mdio_oe ? o_mdio : (drv_en ? drv : 1'b1);

    pmcs_phy_regs pmcs_phy_regs_i (
        .i_clock(i_clock), .i_reset(i_reset), .i_clk_en(1'b1),
        .i_mdc(mdc), .i_mdio(mdio_line), .o_mdio(o_mdio),
        .o_mdio_oe(o_mdio_oe), .i_phy_addr(phy_addr),
        .i_flp_link_good(good), .i_link_lost(lost),
        .i_link_speed(link_spd), .o_an_enable(o_an_enable),
        .o_an_restart(), .o_soft_reset(), .o_loopback(o_loopback),
        .o_power_down(o_power_down), .o_isolate(o_isolate),
        .o_line_speed(o_line_speed), .o_line_full_duplex(o_line_full_duplex),
        .o_tx_silent(o_tx_silent), .o_gig_advert_only(o_gig_advert_only)
    );
    pmcs_link_partner pmcs_link_partner_i (
        .i_clock(i_clock), .o_link_good(good), .o_link_lost(lost),
        .o_link_speed(link_spd)
    );

    always #4 i_clock = ~i_clock;

    // ----------
    // checking
    // ----------
    task automatic wrap_up();
        if (exp_q.size() != 0) begin
            err_total++;
            $display("mismatch at %0t: read never answered", $time);
        end
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: read %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_line(input pmcs_speed_t s, input logic fd);
        checks++;
        if ({o_line_speed, o_line_full_duplex, o_tx_silent, o_gig_advert_only}
                !== {s, fd, 2'b00}) begin
            err_total++;
            $display("mismatch at %0t: line setup wrong", $time);
        end
    endtask

    task automatic cmp_mode(input logic [3:0] exp);
        checks++;
        if ({o_an_enable, o_loopback, o_power_down, o_isolate} !== exp) begin
            err_total++;
            $display("mismatch at %0t: control levels wrong", $time);
        end
    endtask

    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            $display("mismatch at %0t: timeout", $time);
            wrap_up();
        end
    end

    // collect the device's read word while it drives
    always @(posedge mdc) if (o_mdio_oe) shreg <= {shreg[30:0], mdio_line};
    always @(negedge o_mdio_oe) if (!i_reset) begin
        if (exp_q.size() == 0) begin
            err_total++;
            $display("mismatch at %0t: unexpected read", $time);
        end else
            cmp_word(shreg[15:0], exp_q.pop_front());
    end

    // ----------
    // management master
    // ----------
    task automatic mbit(input logic b, input logic en);
        mdc = 1'b0;
        drv = b;
        drv_en = en;
        repeat (2) @(negedge i_clock);
        mdc = 1'b1;
        repeat (2) @(negedge i_clock);
    endtask

    task automatic frame(input logic rd, input logic [4:0] pa,
                         input logic [4:0] ra, input logic [15:0] wd);
        logic [31:0] hdr;
        hdr = {2'b01, rd ? 2'b10 : 2'b01, pa, ra, rd ? 2'b11 : 2'b10, wd};
        repeat (32) mbit(1'b1, 1'b1);
        for (int i = 31; i >= 0; i--) mbit(hdr[i], !(rd && i < 18));
        drv_en = 1'b0;
        // an edge passes before a following frame drives again
        @(negedge i_clock);
    endtask

    task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
        exp_q.push_back(exp);
        frame(1'b1, phy_addr, ra, 16'h0000);
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        frame(1'b0, phy_addr, ra, wd);
        repeat (2) @(negedge i_clock);
    endtask

    initial begin
        logic [1:0]  c;
        logic        d;
        logic [15:0] w;
        repeat (16) @(negedge i_clock);
        i_reset = 1'b0;
        cmp_line(PMCS_SPD_1000, 1'b0);
        rd(5'h00, 16'h1040);
        rd(5'h01, 16'h7909);
        rd(5'h0f, 16'h3000);
        rd(5'h02, 16'h0000);
        w = 16'($random(seed));
        wr(5'h01, w);
        rd(5'h01, 16'h7909);
        $display("test reset values done");
        pmcs_link_partner_i.link_up(PMCS_SPD_100, 20);
        rd(5'h01, 16'h792d);
        rd(5'h00, 16'h3000);
        pmcs_link_partner_i.link_down();
        rd(5'h01, 16'h7909);
        wr(5'h00, 16'h3100);
        cmp_line(PMCS_SPD_1000, 1'b0);
        rd(5'h00, 16'h3100);
        $display("test negotiated link done");
        spd = PMCS_SPD_1000;
        for (int k = 0; k < 8; k++) begin
            c = k[1:0];
            d = 1'($random(seed));
            // reserved code must leave the previous speed in place
            if (c != 2'h3) spd = pmcs_speed_t'(c);
            wr(5'h00, {2'b00, c[0], 4'h0, d, 1'b0, c[1], 6'h00});
            cmp_line(spd, d);
            rd(5'h00, {2'b00, spd[0], 4'h0, d, 1'b0, spd[1], 6'h00});
        end
        $display("test forced speed done");
        pmcs_link_partner_i.link_up(PMCS_SPD_10, 0);
        rd(5'h01, 16'h790d);
        pmcs_link_partner_i.link_down();
        rd(5'h01, 16'h7909);
        frame(1'b0, 5'h1a, 5'h00, 16'h0000);
        repeat (2) @(negedge i_clock);
        cmp_line(spd, d);
        $display("test forced link done");
        wr(5'h00, 16'h8000);
        cmp_line(PMCS_SPD_1000, 1'b0);
        cmp_mode(4'h8);
        wr(5'h00, 16'h5e40);
        cmp_mode(4'hf);
        rd(5'h00, 16'h5c40);
        $display("test soft reset done");
        wrap_up();
    end
endmodule
